/* File: low_power_and_clock_switch.sv */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module low_power_and_clock_switch
  import lp_clk_pkg::*;
(
  input wire logic clk, // peripheral-bus clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [lp_clk_pkg::ADDR_W-1:0] regAddr, // register byte address
  input wire logic [lp_clk_pkg::DATA_W-1:0] regWrData, // register write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  output logic [lp_clk_pkg::DATA_W-1:0] regRdData, // read data, cycle after strobe
  input wire logic wfiExec, // core executed wait-for-interrupt, pulse
  input wire logic wakeIrq, // wake interrupt seen by the power controller
  output logic lpWaitMode, // device in wait mode
  output logic lpStopMode, // device in stop mode
  output lp_clk_pkg::gate_cfg_type gateCfg, // gate enables to image unit and checkers
  output lp_clk_pkg::div_cfg_type divCfg, // selects, post-divider, divider gate
  output logic fastClkPass, // fast clock gate pass state
  output logic imageUnitReset, // image unit reset, active high
  output logic seqBusy // switch sequencer running
);
  import lp_clk_pkg::*;

  logic [1:0] lpMode_reg;
  logic [1:0] lpMode_next;
  power_state_type powerState_reg;
  power_state_type powerState_next;
  logic lpWait_reg;
  logic lpWait_next;
  logic lpStop_reg;
  logic lpStop_next;
  gate_cfg_type gate_reg;
  gate_cfg_type gate_next;
  div_cfg_type div_reg;
  div_cfg_type div_next;
  seq_state_type seqState_reg;
  seq_state_type seqState_next;
  logic [2:0] savedDiv_reg;
  logic [2:0] savedDiv_next;
  logic target_reg;
  logic target_next;
  logic wantChk1_reg;
  logic wantChk1_next;
  logic wantChk2_reg;
  logic wantChk2_next;
  logic unitReset_reg;
  logic unitReset_next;
  logic busy_reg;
  logic busy_next;
  logic pass_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  logic dlyLoad;
  logic [CNT_W-1:0] dlyVal;
  logic dlyExpired;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // mode field write and power state; a mode write alone never moves the state
  always_comb begin
    lpMode_next = lpMode_reg;
    powerState_next = powerState_reg;
    if (regWrite && hit(regAddr, OFF_LP_CTRL)) begin
      lpMode_next = regWrData[LP_MODE_LSB +: 2];
    end
    case (powerState_reg)
      PS_RUN: begin
        if (wfiExec && lpMode_reg == MODE_WAIT) begin
          powerState_next = PS_WAIT;
        end else if (wfiExec && lpMode_reg == MODE_STOP) begin
          powerState_next = PS_STOP;
        end
      end
      PS_WAIT, PS_STOP: begin
        if (wakeIrq) begin
          powerState_next = PS_RUN;
        end
      end
      default: powerState_next = PS_RUN;
    endcase
    lpWait_next = (powerState_next == PS_WAIT);
    lpStop_next = (powerState_next == PS_STOP);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lpMode_reg <= MODE_RUN;
      powerState_reg <= PS_RUN;
      lpWait_reg <= 1'b0;
      lpStop_reg <= 1'b0;
    end else begin
      lpMode_reg <= lpMode_next;
      powerState_reg <= powerState_next;
      lpWait_reg <= lpWait_next;
      lpStop_reg <= lpStop_next;
    end
  end

  // settle timer shared by both fixed waits
  cycle_delay #(.CNT_W(CNT_W)) settleTimer (
    .clk(clk),
    .rst_n(rst_n),
    .load(dlyLoad),
    .loadVal(dlyVal),
    .expired(dlyExpired)
  );

  // switch sequencer plus software writes to gates and dividers;
  // software writes are dropped while the sequencer owns these fields
  always_comb begin
    seqState_next = seqState_reg;
    gate_next = gate_reg;
    div_next = div_reg;
    savedDiv_next = savedDiv_reg;
    target_next = target_reg;
    wantChk1_next = wantChk1_reg;
    wantChk2_next = wantChk2_reg;
    unitReset_next = 1'b0;
    dlyLoad = 1'b0;
    dlyVal = GATE_SETTLE_CYCLES;
    case (seqState_reg)
      SEQ_IDLE: begin
        if (regWrite && hit(regAddr, OFF_GATE_CTRL)) begin
          gate_next.img = regWrData[GATE_IMG_LSB +: 2];
          gate_next.chk1 = regWrData[GATE_CHK1_LSB +: 2];
          gate_next.chk2 = regWrData[GATE_CHK2_LSB +: 2];
        end
        if (regWrite && hit(regAddr, OFF_DIV_CTRL)) begin
          div_next.postDiv = regWrData[DIV_POST_LSB +: 3];
          div_next.lvdsSel = regWrData[DIV_LVDS_SEL_BIT];
          div_next.fastSel = regWrData[DIV_FAST_SEL_BIT];
          div_next.fracGate = regWrData[DIV_FRAC_GATE_BIT];
        end
        if (regWrite && hit(regAddr, OFF_SEQ_CMD) && regWrData[CMD_START_BIT]) begin
          gate_next = '{chk2: GATE_OFF, chk1: GATE_OFF, img: GATE_OFF};
          savedDiv_next = div_reg.postDiv;
          target_next = regWrData[CMD_SEL_BIT];
          wantChk1_next = regWrData[CMD_CHK1_BIT];
          wantChk2_next = regWrData[CMD_CHK2_BIT];
          seqState_next = SEQ_GATE_OFF;
        end
      end
      SEQ_GATE_OFF: begin
        dlyLoad = 1'b1;
        dlyVal = GATE_SETTLE_CYCLES;
        seqState_next = SEQ_WAIT_GATE;
      end
      SEQ_WAIT_GATE: begin
        if (dlyExpired) begin
          div_next.postDiv = DIV_PARK;
          seqState_next = SEQ_DIV_PARK;
        end
      end
      SEQ_DIV_PARK: begin
        dlyLoad = 1'b1;
        dlyVal = DIV_SETTLE_CYCLES;
        seqState_next = SEQ_WAIT_DIV;
      end
      SEQ_WAIT_DIV: begin
        if (dlyExpired) begin
          div_next.fracGate = 1'b1;
          seqState_next = SEQ_FRAC_OFF;
        end
      end
      SEQ_FRAC_OFF: begin
        div_next.fastSel = target_reg;
        seqState_next = SEQ_SWITCH;
      end
      SEQ_SWITCH: begin
        div_next.postDiv = savedDiv_reg;
        seqState_next = SEQ_RESTORE;
      end
      SEQ_RESTORE: begin
        div_next.fracGate = 1'b0;
        seqState_next = SEQ_FRAC_ON;
      end
      SEQ_FRAC_ON: begin
        unitReset_next = 1'b1;
        seqState_next = SEQ_UNIT_RESET;
      end
      SEQ_UNIT_RESET: begin
        gate_next.img = GATE_ON;
        gate_next.chk1 = wantChk1_reg ? GATE_ON : GATE_OFF;
        gate_next.chk2 = wantChk2_reg ? GATE_ON : GATE_OFF;
        seqState_next = SEQ_ENABLE;
      end
      SEQ_ENABLE: begin
        seqState_next = SEQ_IDLE;
      end
      default: seqState_next = SEQ_IDLE;
    endcase
    busy_next = (seqState_next != SEQ_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seqState_reg <= SEQ_IDLE;
      gate_reg <= GATE_CFG_RESET;
      div_reg <= DIV_CFG_RESET;
      savedDiv_reg <= DIV_RESET_VAL;
      target_reg <= 1'b0;
      wantChk1_reg <= 1'b0;
      wantChk2_reg <= 1'b0;
      unitReset_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      seqState_reg <= seqState_next;
      gate_reg <= gate_next;
      div_reg <= div_next;
      savedDiv_reg <= savedDiv_next;
      target_reg <= target_next;
      wantChk1_reg <= wantChk1_next;
      wantChk2_reg <= wantChk2_next;
      unitReset_reg <= unitReset_next;
      busy_reg <= busy_next;
    end
  end

  // the fast clock gate ignores its enable field, so it always passes;
  // this is why the sequencer parks the divider before touching the mux
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pass_reg <= 1'b1;
    end else begin
      pass_reg <= 1'b1;
    end
  end

  // read mux; data stands only in the cycle after the strobe, unmapped reads zero
  always_comb begin
    rdData_next = '0;
    if (regRead) begin
      case (1'b1)
        hit(regAddr, OFF_LP_CTRL): rdData_next[LP_MODE_LSB +: 2] = lpMode_reg;
        hit(regAddr, OFF_GATE_CTRL): begin
          rdData_next[GATE_IMG_LSB +: 2] = gate_reg.img;
          rdData_next[GATE_CHK1_LSB +: 2] = gate_reg.chk1;
          rdData_next[GATE_CHK2_LSB +: 2] = gate_reg.chk2;
        end
        hit(regAddr, OFF_DIV_CTRL): begin
          rdData_next[DIV_POST_LSB +: 3] = div_reg.postDiv;
          rdData_next[DIV_LVDS_SEL_BIT] = div_reg.lvdsSel;
          rdData_next[DIV_FAST_SEL_BIT] = div_reg.fastSel;
          rdData_next[DIV_FRAC_GATE_BIT] = div_reg.fracGate;
        end
        hit(regAddr, OFF_STATUS): begin
          rdData_next[STAT_PWR_LSB +: 3] = powerState_reg;
          rdData_next[STAT_BUSY_BIT] = busy_reg;
          rdData_next[STAT_SEQ_LSB +: 11] = seqState_reg;
        end
        default: rdData_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;
  assign lpWaitMode = lpWait_reg;
  assign lpStopMode = lpStop_reg;
  assign gateCfg = gate_reg;
  assign divCfg = div_reg;
  assign fastClkPass = pass_reg;
  assign imageUnitReset = unitReset_reg;
  assign seqBusy = busy_reg;

  // checks
  sequence s_allGated;
    gate_reg.img == GATE_OFF && gate_reg.chk1 == GATE_OFF && gate_reg.chk2 == GATE_OFF;
  endsequence

  sequence s_divSwap;
    div_reg.fracGate ##1 (div_reg.fastSel == target_reg && div_reg.fracGate)
      ##1 (div_reg.postDiv == savedDiv_reg) ##1 !div_reg.fracGate;
  endsequence

  property p_waitEntry;
    @(posedge clk) disable iff (!rst_n)
      $rose(lpWait_reg) |-> $past(wfiExec) && $past(lpMode_reg) == MODE_WAIT;
  endproperty
  a_waitEntry: assert property (p_waitEntry) else $error("wait entered without wfi");

  property p_noEntryWithoutWfi;
    @(posedge clk) disable iff (!rst_n)
      (powerState_reg == PS_RUN && !wfiExec) |=> !lpWait_reg && !lpStop_reg;
  endproperty
  a_noEntryWithoutWfi: assert property (p_noEntryWithoutWfi)
    else $error("low power entered without wfi");

  property p_stopSelect;
    @(posedge clk) disable iff (!rst_n)
      (powerState_reg == PS_RUN && wfiExec && lpMode_reg == MODE_STOP)
        |=> lpStop_reg && !lpWait_reg;
  endproperty
  a_stopSelect: assert property (p_stopSelect) else $error("stop mode not selected");

  property p_runSelect;
    @(posedge clk) disable iff (!rst_n)
      (powerState_reg == PS_RUN && wfiExec && lpMode_reg == MODE_RUN)
        |=> !lpStop_reg && !lpWait_reg;
  endproperty
  a_runSelect: assert property (p_runSelect) else $error("run mode left on wfi");

  property p_lvdsImmediate;
    @(posedge clk) disable iff (!rst_n)
      (regWrite && hit(regAddr, OFF_DIV_CTRL) && seqState_reg == SEQ_IDLE)
        |=> divCfg.lvdsSel == $past(regWrData[DIV_LVDS_SEL_BIT]);
  endproperty
  a_lvdsImmediate: assert property (p_lvdsImmediate) else $error("lvds select lagged");

  property p_gatePasses;
    @(posedge clk) disable iff (!rst_n)
      (seqState_reg == SEQ_SWITCH) |-> fastClkPass;
  endproperty
  a_gatePasses: assert property (p_gatePasses) else $error("fast clock gate blocked");

  property p_gateSettle;
    @(posedge clk) disable iff (!rst_n)
      (seqState_reg == SEQ_GATE_OFF) |-> (s_allGated [*8] ##1 s_allGated [*5])
        ##0 (seqState_reg == SEQ_DIV_PARK && div_reg.postDiv == DIV_PARK);
  endproperty
  a_gateSettle: assert property (p_gateSettle) else $error("gate settle wrong");

  property p_divSettle;
    @(posedge clk) disable iff (!rst_n)
      (seqState_reg == SEQ_DIV_PARK) |-> ##32 (seqState_reg == SEQ_FRAC_OFF
        && div_reg.postDiv == DIV_PARK && !imageUnitReset);
  endproperty
  a_divSettle: assert property (p_divSettle) else $error("divider settle wrong");

  property p_divSwap;
    @(posedge clk) disable iff (!rst_n)
      (seqState_reg == SEQ_FRAC_OFF) |-> s_divSwap;
  endproperty
  a_divSwap: assert property (p_divSwap) else $error("switch order wrong");

  property p_resetThenEnable;
    @(posedge clk) disable iff (!rst_n)
      (seqState_reg == SEQ_FRAC_ON) |=> imageUnitReset && gate_reg.img == GATE_OFF
        ##1 !imageUnitReset && gate_reg.img == GATE_ON ##1 !seqBusy;
  endproperty
  a_resetThenEnable: assert property (p_resetThenEnable) else $error("reset order wrong");

endmodule

/* File: lp_clk_pkg.sv */
package lp_clk_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_LP_CTRL = 8'h00;
  localparam logic [7:0] OFF_GATE_CTRL = 8'h04;
  localparam logic [7:0] OFF_DIV_CTRL = 8'h08;
  localparam logic [7:0] OFF_SEQ_CMD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // low-power mode field encodings
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_WAIT = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;

  // gate enable encodings
  localparam logic [1:0] GATE_OFF = 2'h0;
  localparam logic [1:0] GATE_ON = 2'h3;

  // post-divider parking value and reset value
  localparam logic [2:0] DIV_PARK = 3'h0;
  localparam logic [2:0] DIV_RESET_VAL = 3'h1;

  // field positions
  localparam int LP_MODE_LSB = 0;
  localparam int GATE_IMG_LSB = 0;
  localparam int GATE_CHK1_LSB = 2;
  localparam int GATE_CHK2_LSB = 4;
  localparam int DIV_POST_LSB = 0;
  localparam int DIV_LVDS_SEL_BIT = 4;
  localparam int DIV_FAST_SEL_BIT = 8;
  localparam int DIV_FRAC_GATE_BIT = 12;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_SEL_BIT = 1;
  localparam int CMD_CHK1_BIT = 2;
  localparam int CMD_CHK2_BIT = 3;
  localparam int STAT_PWR_LSB = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_SEQ_LSB = 8;

  // delays in peripheral-bus clock cycles
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] GATE_SETTLE_CYCLES = 5'h0A;
  localparam logic [CNT_W-1:0] DIV_SETTLE_CYCLES = 5'h1E;

  typedef enum logic [2:0] {
    PS_RUN = 3'b001,
    PS_WAIT = 3'b010,
    PS_STOP = 3'b100
  } power_state_type;

  typedef enum logic [10:0] {
    SEQ_IDLE = 11'b00000000001,
    SEQ_GATE_OFF = 11'b00000000010,
    SEQ_WAIT_GATE = 11'b00000000100,
    SEQ_DIV_PARK = 11'b00000001000,
    SEQ_WAIT_DIV = 11'b00000010000,
    SEQ_FRAC_OFF = 11'b00000100000,
    SEQ_SWITCH = 11'b00001000000,
    SEQ_RESTORE = 11'b00010000000,
    SEQ_FRAC_ON = 11'b00100000000,
    SEQ_UNIT_RESET = 11'b01000000000,
    SEQ_ENABLE = 11'b10000000000
  } seq_state_type;

  typedef struct packed {
    logic [1:0] chk2;
    logic [1:0] chk1;
    logic [1:0] img;
  } gate_cfg_type;

  typedef struct packed {
    logic fracGate;
    logic fastSel;
    logic lvdsSel;
    logic [2:0] postDiv;
  } div_cfg_type;

  localparam gate_cfg_type GATE_CFG_RESET = '{chk2: GATE_ON, chk1: GATE_ON, img: GATE_ON};
  localparam div_cfg_type DIV_CFG_RESET = '{fracGate: 1'b0, fastSel: 1'b0, lvdsSel: 1'b0,
                                            postDiv: DIV_RESET_VAL};

endpackage

/* File: cycle_delay.sv */
`timescale 1ns/1ps
module cycle_delay #(
  parameter int CNT_W = 5
) (
  input wire logic clk, // peripheral-bus clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic load, // start a new wait
  input wire logic [CNT_W-1:0] loadVal, // cycles to wait
  output logic expired // count has run out
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // down counter, parked at zero when idle
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = loadVal;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // a load in this cycle hides a stale zero
  assign expired = (cnt_reg == '0) && !load;

endmodule

/* File: test_low_power_and_clock_switch.sv */
`timescale 1ns/1ps
module test_low_power_and_clock_switch;
  import lp_clk_pkg::*;

  logic clk;
  logic rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [DATA_W-1:0] regRdData;
  logic wfiExec;
  logic wakeIrq;
  logic lpWaitMode;
  logic lpStopMode;
  gate_cfg_type gateCfg;
  div_cfg_type divCfg;
  logic fastClkPass;
  logic imageUnitReset;
  logic seqBusy;
  int fails;
  int checks;
  int cycleCount;
  logic [DATA_W-1:0] rdVal;

  low_power_and_clock_switch low_power_and_clock_switch_i (
    .clk(clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .wfiExec(wfiExec),
    .wakeIrq(wakeIrq),
    .lpWaitMode(lpWaitMode),
    .lpStopMode(lpStopMode),
    .gateCfg(gateCfg),
    .divCfg(divCfg),
    .fastClkPass(fastClkPass),
    .imageUnitReset(imageUnitReset),
    .seqBusy(seqBusy)
  );

  // 200 MHz peripheral-bus clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard: the whole run needs under two hundred cycles
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe; returns at the edge that takes it
  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= addr;
    regWrData <= data;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    data = regRdData;
  endtask

  // advance n edges and sample once outputs have settled
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // mode write, then wait-for-interrupt, then wake
  task automatic lp_cycle(input logic [1:0] mode, input logic [2:0] expState);
    reg_write(OFF_LP_CTRL, {30'h0, mode});
    waitc(3);
    check("lp modes before wfi", 32'h0, {30'h0, lpWaitMode, lpStopMode});
    @(posedge clk);
    wfiExec <= 1'b1;
    @(posedge clk);
    wfiExec <= 1'b0;
    #1;
    check("lp wait", {31'h0, expState[1]}, {31'h0, lpWaitMode});
    check("lp stop", {31'h0, expState[2]}, {31'h0, lpStopMode});
    reg_read(OFF_STATUS, rdVal);
    check("status power", {23'h0, 1'b1, 5'h0, expState}, rdVal);
    // the forced wake line is visible to the power controller, so it ends the state
    @(posedge clk);
    wakeIrq <= 1'b1;
    @(posedge clk);
    wakeIrq <= 1'b0;
    #1;
    check("lp after wake", 32'h0, {30'h0, lpWaitMode, lpStopMode});
  endtask

  // hardware switch sequence, sampled against the fixed step timeline
  task automatic run_seq(input logic [31:0] cmd, input logic [2:0] pd, input logic lv);
    logic [1:0] c1g;
    logic [1:0] c2g;
    c1g = cmd[2] ? GATE_ON : GATE_OFF;
    c2g = cmd[3] ? GATE_ON : GATE_OFF;
    reg_write(OFF_DIV_CTRL, {27'h0, lv, 1'b0, pd});
    reg_write(OFF_SEQ_CMD, cmd);
    #1;
    check("gates off", 32'h0, {26'h0, gateCfg});
    check("busy", 32'h1, {31'h0, seqBusy});
    check("fast pass", 32'h1, {31'h0, fastClkPass});
    // a gate write while busy must not reopen the clock early
    reg_write(OFF_GATE_CTRL, 32'h3F);
    // now in cycle 3 after the command; the park lands in cycle 13
    waitc(9);
    check("div before park", {26'h0, 2'h0, lv, pd}, {26'h0, divCfg});
    waitc(1);
    check("div parked", {26'h0, 2'h0, lv, DIV_PARK}, {26'h0, divCfg});
    check("gate refused", 32'h0, {26'h0, gateCfg});
    waitc(31);
    check("div settle", {26'h0, 2'h0, lv, DIV_PARK}, {26'h0, divCfg});
    waitc(1);
    check("frac gated", {26'h0, 2'h2, lv, DIV_PARK}, {26'h0, divCfg});
    waitc(1);
    check("switched", {26'h0, 1'b1, cmd[1], lv, DIV_PARK}, {26'h0, divCfg});
    waitc(1);
    check("restored", {26'h0, 1'b1, cmd[1], lv, pd}, {26'h0, divCfg});
    waitc(1);
    check("frac on", {26'h0, 1'b0, cmd[1], lv, pd}, {26'h0, divCfg});
    waitc(1);
    check("unit reset", 32'h1, {31'h0, imageUnitReset});
    waitc(1);
    check("reset done", 32'h0, {31'h0, imageUnitReset});
    check("gates on", {26'h0, c2g, c1g, GATE_ON}, {26'h0, gateCfg});
    waitc(1);
    check("idle", 32'h0, {31'h0, seqBusy});
    check("fast pass end", 32'h1, {31'h0, fastClkPass});
  endtask

  initial begin
    fails = 0;
    checks = 0;
    cycleCount = 0;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    wfiExec = 1'b0;
    wakeIrq = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    waitc(1);
    check("gate reset", 32'h3F, {26'h0, gateCfg});
    check("div reset", {26'h0, 3'h0, DIV_RESET_VAL}, {26'h0, divCfg});
    check("pass reset", 32'h1, {31'h0, fastClkPass});
    // every mode code, unused 11 included
    lp_cycle(MODE_WAIT, 3'b010);
    lp_cycle(MODE_STOP, 3'b100);
    lp_cycle(MODE_RUN, 3'b001);
    lp_cycle(2'h3, 3'b001);
    // wait written after a run-mode wake must still hold off until a fresh wfi
    lp_cycle(MODE_WAIT, 3'b010);
    // lvds select follows the write at once; its sources are stopped around it
    reg_write(OFF_DIV_CTRL, 32'h1000);
    reg_write(OFF_DIV_CTRL, 32'h1010);
    #1;
    check("lvds sel", {26'h0, 3'h5, 3'h0}, {26'h0, divCfg});
    reg_write(OFF_DIV_CTRL, 32'h10);
    #1;
    check("lvds sources on", {26'h0, 3'h1, 3'h0}, {26'h0, divCfg});
    reg_write(OFF_DIV_CTRL, 32'h0);
    #1;
    check("lvds back", 32'h0, {26'h0, divCfg});
    run_seq(32'h7, 3'h5, 1'b1);
    reg_write(OFF_GATE_CTRL, 32'h3F);
    #1;
    check("gate after idle", 32'h3F, {26'h0, gateCfg});
    run_seq(32'h9, 3'h2, 1'b0);
    reg_read(OFF_SEQ_CMD, rdVal);
    check("cmd reads zero", 32'h0, rdVal);
    reg_read(8'h40, rdVal);
    check("unmapped read", 32'h0, rdVal);
    waitc(1);
    check("rd data drops", 32'h0, regRdData);
    report_and_stop();
  end
endmodule
